/* rtl/lane_health_pkg.sv */
// constants for the lane 6/7 link health status bank
// Notes on behaviour
// RL1 - lane 6 bit 7 high when disparity error count at or above limit
// RL2 - lane 6 bit 6 high when invalid code count at or above limit
// RL3 - lane 6 bit 5 high when stray control count at or above limit
// RL4 - lane 6 bit 4 shows interlane deskew achieved
// RL5 - lane 6 bit 3 shows initial lane alignment achieved
// RL6 - lane 6 bit 2 shows computed checksum correct
// RL7 - lane 6 bit 1 shows frame synchronisation achieved
// RL8 - lane 6 bit 0 shows code group synchronisation achieved
// RL9 - lane 7 register at 0x4B7, bit 7 disparity count at or above limit
// RL10 - lane 7 bit 6 high when invalid code count at or above limit
// RL11 - lane 7 bit 5 high when stray control count at or above limit
// RL12 - lane 7 bit 4 shows interlane deskew achieved
// RL13 - fields show the page-selected link, read only, reset to zero
// RL14 - error bits compare running count to 8-bit limit; reads change nothing
package lane_health_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses, index times four)
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] LANE6_IDX     = 12'h04b6;
   localparam logic [11:0] LANE7_IDX     = 12'h04b7;
   localparam logic [11:0] LINK_PAGE_IDX = 12'h0300;
   localparam logic [11:0] ERR_LIMIT_IDX = 12'h0301;
   localparam logic [11:0] IRQ_STAT_IDX  = 12'h0302;
   localparam logic [11:0] IRQ_MASK_IDX  = 12'h0303;
   localparam logic [13:0] LANE6_ADDR     = {LANE6_IDX, 2'b00};
   localparam logic [13:0] LANE7_ADDR     = {LANE7_IDX, 2'b00};
   localparam logic [13:0] LINK_PAGE_ADDR = {LINK_PAGE_IDX, 2'b00};
   localparam logic [13:0] ERR_LIMIT_ADDR = {ERR_LIMIT_IDX, 2'b00};
   localparam logic [13:0] IRQ_STAT_ADDR  = {IRQ_STAT_IDX, 2'b00};
   localparam logic [13:0] IRQ_MASK_ADDR  = {IRQ_MASK_IDX, 2'b00};
   // ----------------------------------------------------------------
   // field positions of a lane health byte
   // ----------------------------------------------------------------
   localparam int DISP_BIT   = 7;
   localparam int INVAL_BIT  = 6;
   localparam int STRAY_BIT  = 5;
   localparam int DESKEW_BIT = 4;
   localparam int ALIGN_BIT  = 3;
   localparam int CKSUM_BIT  = 2;
   localparam int FRAME_BIT  = 1;
   localparam int CGS_BIT    = 0;
   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_LINKS   = 2;
   localparam int         CNT_W       = 8;
   localparam logic [7:0] STATUS_RST  = 8'h00;
   localparam logic [7:0] LIMIT_RST   = 8'hff;
   localparam logic [7:0] CNT_MAX     = 8'hff;
   localparam logic [7:0] MASK_RST    = 8'h00;
endpackage : lane_health_pkg

/* rtl/lane_err_counter.sv */
// saturating per-lane error counter with threshold compare
`timescale 1ns/100ps
module lane_err_counter (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       err_hit,
   input  wire logic       clear,
   input  wire logic [7:0] limit,
   output logic            at_limit
);
   logic [7:0] count;

   // count errors, hold at full scale, clear on request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count <= 8'h00;
      end else if (clear) begin
         count <= 8'h00;
      end else if (err_hit && count != lane_health_pkg::CNT_MAX) begin
         count <= count + 8'h01;
      end
   end

   // registered compare against the limit
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         at_limit <= 1'b0;
      end else begin
         at_limit <= (count >= limit);   // see RL14
      end
   end
endmodule : lane_err_counter

/* rtl/lane_health_regs.sv */
// lane 6/7 link health status bank with classic wishbone slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module lane_health_regs (
   input  wire logic        mclk,
   input  wire logic        rstn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // per-link error events, [link][lane 6 / lane 7]
   input  wire logic [1:0]  disp_err_l6,
   input  wire logic [1:0]  inval_err_l6,
   input  wire logic [1:0]  stray_err_l6,
   input  wire logic [1:0]  disp_err_l7,
   input  wire logic [1:0]  inval_err_l7,
   input  wire logic [1:0]  stray_err_l7,
   input  wire logic [1:0]  count_clear,
   // per-link synchronisation levels
   input  wire logic [1:0]  deskew_l6,
   input  wire logic [1:0]  align_l6,
   input  wire logic [1:0]  cksum_l6,
   input  wire logic [1:0]  frame_l6,
   input  wire logic [1:0]  cgs_l6,
   input  wire logic [1:0]  deskew_l7,
   // interrupt
   output logic             irq
);
   // ----------------------------------------------------------------
   // local field positions and fixed fill values
   // ----------------------------------------------------------------
   localparam int          ERR_HI    = lane_health_pkg::DISP_BIT;
   localparam int          ERR_LO    = lane_health_pkg::STRAY_BIT;
   localparam int          L7_TOP    = lane_health_pkg::ALIGN_BIT;
   localparam int          ADR_LO    = $bits(lane_health_pkg::LANE6_ADDR);
   localparam int          ADR_HI    = ADR_LO + 1;
   localparam logic [1:0]  HIGH_NONE = 2'b00;  // upper address bits unused
   localparam logic [3:0]  L7_FILL   = 4'h0;   // lane 7 low bits read zero
   localparam logic [6:0]  PAGE_PAD  = 7'h00;  // page register spare bits
   localparam logic [23:0] DAT_PAD   = 24'h00_0000;

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   logic       link_page;
   logic [7:0] error_limit;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   // threshold flags of every counter, indexed by link
   logic [1:0] disp6_hit, inval6_hit, stray6_hit;
   logic [1:0] disp7_hit, inval7_hit, stray7_hit;
   logic [7:0] lane6_link_health;
   logic [7:0] lane7_link_health;
   logic [7:0] lane6_prev;
   logic [7:0] lane7_prev;

   // ----------------------------------------------------------------
   // error counters, one set per link
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < lane_health_pkg::NUM_LINKS; g++) begin : g_link
         // six counters per link, all compared against one limit
         // lane 6 bad disparity count
         lane_err_counter u_disp6 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (disp_err_l6[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(disp6_hit[g])
         );
         // lane 6 invalid code count
         lane_err_counter u_inval6 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (inval_err_l6[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(inval6_hit[g])
         );
         // lane 6 stray control count
         lane_err_counter u_stray6 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (stray_err_l6[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(stray6_hit[g])
         );
         // lane 7 bad disparity count
         lane_err_counter u_disp7 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (disp_err_l7[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(disp7_hit[g])
         );
         // lane 7 invalid code count
         lane_err_counter u_inval7 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (inval_err_l7[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(inval7_hit[g])
         );
         // lane 7 stray control count
         lane_err_counter u_stray7 (
            .mclk    (mclk),
            .rstn    (rstn),
            .err_hit (stray_err_l7[g]),
            .clear   (count_clear[g]),
            .limit   (error_limit),
            .at_limit(stray7_hit[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        req;
   logic        wr_ok;
   logic        hit_page, hit_limit, hit_stat, hit_mask, hit_l6, hit_l7;
   logic        mapped;
   logic [13:0] byte_adr;

   // low address bits select the register
   assign byte_adr  = wb_adr_i[ADR_LO-1:0];
   // taken once, while no answer is out
   assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   // one decode per register
   assign hit_page  = byte_adr == lane_health_pkg::LINK_PAGE_ADDR;
   assign hit_limit = byte_adr == lane_health_pkg::ERR_LIMIT_ADDR;
   assign hit_stat  = byte_adr == lane_health_pkg::IRQ_STAT_ADDR;
   assign hit_mask  = byte_adr == lane_health_pkg::IRQ_MASK_ADDR;
   assign hit_l6    = byte_adr == lane_health_pkg::LANE6_ADDR;
   assign hit_l7    = byte_adr == lane_health_pkg::LANE7_ADDR;
   // only the low quarter of the map answers
   assign mapped    = (wb_adr_i[ADR_HI:ADR_LO] == HIGH_NONE)
                      && (hit_page || hit_limit || hit_stat || hit_mask
                      || hit_l6 || hit_l7);
   // writes need byte lane 0
   assign wr_ok     = req && wb_we_i && mapped && wb_sel_i[0];

   // ----------------------------------------------------------------
   // paged status bytes
   // ----------------------------------------------------------------
   // status bytes of the selected link, registered
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lane6_link_health <= lane_health_pkg::STATUS_RST;  // see RL13
         lane7_link_health <= lane_health_pkg::STATUS_RST;
      end else begin
         // lane 6: three error flags, then five sync levels
         lane6_link_health[lane_health_pkg::DISP_BIT]
            <= disp6_hit[link_page];                      // see RL1
         lane6_link_health[lane_health_pkg::INVAL_BIT]
            <= inval6_hit[link_page];                     // see RL2
         lane6_link_health[lane_health_pkg::STRAY_BIT]
            <= stray6_hit[link_page];                     // see RL3
         lane6_link_health[lane_health_pkg::DESKEW_BIT]
            <= deskew_l6[link_page];                      // see RL4
         lane6_link_health[lane_health_pkg::ALIGN_BIT]
            <= align_l6[link_page];                       // see RL5
         lane6_link_health[lane_health_pkg::CKSUM_BIT]
            <= cksum_l6[link_page];                       // see RL6
         lane6_link_health[lane_health_pkg::FRAME_BIT]
            <= frame_l6[link_page];                       // see RL7
         lane6_link_health[lane_health_pkg::CGS_BIT]
            <= cgs_l6[link_page];                         // see RL8
         // lane 7: three error flags and deskew
         lane7_link_health[lane_health_pkg::DISP_BIT]
            <= disp7_hit[link_page];                      // see RL9
         lane7_link_health[lane_health_pkg::INVAL_BIT]
            <= inval7_hit[link_page];                     // see RL10
         lane7_link_health[lane_health_pkg::STRAY_BIT]
            <= stray7_hit[link_page];                     // see RL11
         lane7_link_health[lane_health_pkg::DESKEW_BIT]
            <= deskew_l7[link_page];                      // see RL12
         lane7_link_health[L7_TOP:0] <= L7_FILL;  // low bits not in bank
      end
   end

   // previous bytes, for rising edge events on error bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lane6_prev <= lane_health_pkg::STATUS_RST;
         lane7_prev <= lane_health_pkg::STATUS_RST;
      end else begin
         lane6_prev <= lane6_link_health;
         lane7_prev <= lane7_link_health;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // page select, limit and mask writes
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         link_page   <= 1'b0;
         error_limit <= lane_health_pkg::LIMIT_RST;
         irq_mask    <= lane_health_pkg::MASK_RST;
      end else if (wr_ok) begin
         // writes to the status bytes fall through untouched
         if (hit_page) begin
            link_page <= wb_dat_i[0];                     // see RL13
         end
         if (hit_limit) begin
            error_limit <= wb_dat_i[7:0];                 // see RL14
         end
         if (hit_mask) begin
            irq_mask <= wb_dat_i[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status: bits 7..5 lane 6 errors, 4..2 lane 7 errors,
   // bit 1 lane 6 code group sync lost, bit 0 lane 6 frame sync lost
   // ----------------------------------------------------------------
   logic [7:0] irq_event;
   logic       stat_rd;

   // rising error bits and falling lane 6 code group and frame sync bits of the paged bytes
   assign irq_event = {
      lane6_link_health[ERR_HI:ERR_LO] & ~lane6_prev[ERR_HI:ERR_LO],
      lane7_link_health[ERR_HI:ERR_LO] & ~lane7_prev[ERR_HI:ERR_LO],
      ~lane6_link_health[lane_health_pkg::CGS_BIT]
         & lane6_prev[lane_health_pkg::CGS_BIT],
      ~lane6_link_health[lane_health_pkg::FRAME_BIT]
         & lane6_prev[lane_health_pkg::FRAME_BIT]};
   // a status read clears at the edge that takes it
   assign stat_rd = req && !wb_we_i && hit_stat
                    && (wb_adr_i[ADR_HI:ADR_LO] == HIGH_NONE);

   // sticky bits, read clears, a new event wins over the clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_status <= 8'h00;
      end else if (stat_rd) begin
         irq_status <= irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   // interrupt line from flop
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // bus answer: one-cycle ack, err on unmapped address
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;

   // read mux, status reads leave counts untouched
   always_comb begin
      // unmapped addresses read zero and get err
      rd_byte = 8'h00;
      if (hit_l6) begin
         rd_byte = lane6_link_health;                     // see RL14
      end else if (hit_l7) begin
         rd_byte = lane7_link_health;
      end else if (hit_page) begin
         rd_byte = {PAGE_PAD, link_page};
      end else if (hit_limit) begin
         rd_byte = error_limit;
      end else if (hit_stat) begin
         rd_byte = irq_status;
      end else if (hit_mask) begin
         rd_byte = irq_mask;
      end
   end

   // ack, err and read data registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && mapped;
         wb_err_o <= req && !mapped;
         // read data stands with ack only, zero otherwise
         if (req && mapped && !wb_we_i) begin
            wb_dat_o <= {DAT_PAD, rd_byte};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end
endmodule : lane_health_regs

/* tb/lane_src_model.sv */
// transmitter-side model driving lane error events and sync levels
`timescale 1ns/100ps
module lane_src (
   input  wire logic       mclk,
   output logic [5:0][1:0] ev,
   output logic [5:0][1:0] lv
);
   // ----------------------------------------------------------------
   // events and levels, changed just after a rising edge
   // ----------------------------------------------------------------
   // quiet link with nothing achieved until told otherwise
   initial begin
      ev = '0;
      lv = '0;
   end
   // error kind k on one link, high n cycles: one count per cycle
   task automatic hit(input int link, input int k, input int n);
      @(posedge mclk);
      ev[k][link] <= 1'b1;
      repeat (n) @(posedge mclk);
      ev[k][link] <= 1'b0;
   endtask : hit
   // levels: cgs, frame, cksum, align, deskew lane 6, deskew lane 7
   task automatic sync(input int link, input logic [5:0] v);
      @(posedge mclk);
      for (int k = 0; k < 6; k++) begin
         lv[k][link] <= v[k];
      end
   endtask : sync
endmodule : lane_src

/* tb/lane_health_sva.sv */
// bus timing checker for the lane health register bank
`timescale 1ns/100ps
module lane_health_sva (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic take;
   // a request the slave takes at this edge
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_err_single: assert property (wb_err_o |=> !wb_err_o)
      else $error("err held longer than one cycle");
   a_answer_next: assert property (take |=> wb_ack_o ^ wb_err_o)
      else $error("no single answer one cycle after request");
   a_no_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without a request");
   a_high_unmapped: assert property (take && wb_adr_i[15:14] != 2'h0
      |=> wb_err_o) else $error("high address not refused");
   a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_byte_wide: assert property (wb_dat_o[31:8] == 24'h00_0000)
      else $error("read data wider than one byte");
   a_lane6_mapped: assert property (take && wb_adr_i ==
      {2'h0, lane_health_pkg::LANE6_ADDR} |=> wb_ack_o && !wb_err_o)
      else $error("lane 6 health access refused");
   a_lane7_low: assert property (take && !wb_we_i && wb_adr_i ==
      {2'h0, lane_health_pkg::LANE7_ADDR} |=> wb_dat_o[3:0] == 4'h0)
      else $error("lane 7 low bits not zero");
endmodule : lane_health_sva
bind lane_health_regs lane_health_sva chk (.mclk(mclk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o));

/* tb/lane_health_regs_tb_top.sv */
// self-checking bench for the lane health register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   err_total++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module lane_health_regs_tb_top;
   localparam logic [15:0] L6 = {2'h0, lane_health_pkg::LANE6_ADDR};
   localparam logic [15:0] L7 = {2'h0, lane_health_pkg::LANE7_ADDR};
   localparam logic [15:0] PG = {2'h0, lane_health_pkg::LINK_PAGE_ADDR};
   localparam logic [15:0] LIM = {2'h0, lane_health_pkg::ERR_LIMIT_ADDR};
   localparam logic [15:0] STA = {2'h0, lane_health_pkg::IRQ_STAT_ADDR};
   localparam logic [15:0] MSK = {2'h0, lane_health_pkg::IRQ_MASK_ADDR};
   logic mclk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [15:0] adr = 16'h0000;
   logic [3:0] sel = 4'h0, wsel = 4'h1;
   logic [31:0] dat = 32'h0000_0000, rdat, q;
   logic [1:0] clr = 2'b00;
   logic ack, berr, irq, last_err;
   logic [5:0][1:0] ev, lv;
   int err_total = 0, total_checks = 0, cycles = 0;
   // clock and hang guard
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   lane_src src (.mclk(mclk), .ev(ev), .lv(lv));
   lane_health_regs uut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(berr),
      .disp_err_l6(ev[0]), .inval_err_l6(ev[1]), .stray_err_l6(ev[2]),
      .disp_err_l7(ev[3]), .inval_err_l7(ev[4]), .stray_err_l7(ev[5]),
      .count_clear(clr), .cgs_l6(lv[0]), .frame_l6(lv[1]),
      .cksum_l6(lv[2]), .align_l6(lv[3]), .deskew_l6(lv[4]),
      .deskew_l7(lv[5]), .irq(irq));
   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [15:0] a,
                      input logic [7:0] d, output logic [31:0] r);
      @(posedge mclk);
      {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, wsel, 24'h00_0000, d};
      do @(posedge mclk); while (!(ack || berr));
      r = rdat;
      last_err = berr;
      {cyc, stb} <= 2'b00;
   endtask : bus
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd_chk(string n, logic [15:0] a, logic [7:0] e);
      bus(1'b0, a, 8'h00, q);
      `CHK(n, {24'h00_0000, e}, q)
   endtask : rd_chk
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk("lane6", L6, 8'h00);
      rd_chk("lane7", L7, 8'h00);
      rd_chk("limit", LIM, 8'hff);
      rd_chk("mask", MSK, 8'h00);
      `CHK("irq", 1'b0, irq)
   endtask : t_reset
   // each error kind: one below the limit, then exactly at it
   task automatic t_errors();
      logic [7:0] e6, e7;
      e6 = 8'h00;
      e7 = 8'h00;
      wr(LIM, 8'h03);
      for (int k = 0; k < 6; k++) begin
         src.hit(0, k, 2);
         repeat (4) @(posedge mclk);
         rd_chk("below", k < 3 ? L6 : L7, k < 3 ? e6 : e7);
         src.hit(0, k, 1);
         repeat (4) @(posedge mclk);
         if (k < 3) e6[7 - k] = 1'b1;
         else e7[10 - k] = 1'b1;
         rd_chk("at6", L6, e6);
         rd_chk("at7", L7, e7);
         rd_chk("again6", L6, e6);
      end
   endtask : t_errors
   // walking one over the sync levels, then all achieved
   task automatic t_sync();
      logic [5:0] v;
      for (int i = 0; i <= 6; i++) begin
         v = (i == 6) ? 6'h3f : 6'h01 << i;
         src.sync(0, v);
         repeat (2) @(posedge mclk);
         rd_chk("sync6", L6, {3'h7, v[4:0]});
         rd_chk("sync7", L7, {3'h7, v[5], 4'h0});
      end
   endtask : t_sync
   // second link through the page, read-only write, refused accesses
   task automatic t_page();
      src.sync(1, 6'h2a);
      wr(PG, 8'h01);
      repeat (2) @(posedge mclk);
      rd_chk("page", PG, 8'h01);
      wsel = 4'h0;
      wr(PG, 8'h00);
      wsel = 4'h1;
      `CHK("nosel_ack", 1'b0, last_err)
      rd_chk("nosel", PG, 8'h01);
      rd_chk("page6", L6, 8'h0a);
      rd_chk("page7", L7, 8'h10);
      wr(L6, 8'hff);
      rd_chk("ro6", L6, 8'h0a);
      bus(1'b0, 16'h0c10, 8'h00, q);
      `CHK("unmapped", 1'b1, last_err)
      bus(1'b0, L6 | 16'h8000, 8'h00, q);
      `CHK("high", 1'b1, last_err)
      wr(PG, 8'h00);
   endtask : t_page
   // error event held back by the mask, then raised and read clear
   task automatic t_irq();
      wr(MSK, 8'h00);
      @(posedge mclk);
      clr <= 2'b01;
      @(posedge mclk);
      clr <= 2'b00;
      repeat (6) @(posedge mclk);
      bus(1'b0, STA, 8'h00, q);
      src.hit(0, 0, 3);
      repeat (5) @(negedge mclk);
      `CHK("masked", 1'b0, irq)
      wr(MSK, 8'h80);
      repeat (2) @(negedge mclk);
      `CHK("raised", 1'b1, irq)
      rd_chk("status", STA, 8'h80);
      repeat (2) @(negedge mclk);
      `CHK("cleared", 1'b0, irq)
      src.hit(0, 3, 3);
      repeat (5) @(negedge mclk);
      `CHK("masked7", 1'b0, irq)
      rd_chk("status7", STA, 8'h10);
   endtask : t_irq
   task automatic end_of_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_errors();
      t_sync();
      t_page();
      t_irq();
      end_of_test();
   end
endmodule : lane_health_regs_tb_top
